// File: wdt_pkg.sv
package wdt_pkg;
    // Register map, one aligned word
    localparam logic [11:0] WDT_CTRL_ADDR = 12'h01C;
    localparam logic [31:0] WDT_CTRL_RESET = 32'h0000_0400;
    // Field positions
    localparam int KICK_BIT = 0;
    localparam int RST_EN_BIT = 1;
    localparam int RST_FLAG_BIT = 2;
    localparam int IRQ_FLAG_BIT = 3;
    localparam int SEL_LO_BIT = 4;
    localparam int IRQ_EN_BIT = 6;
    localparam int RUN_EN_BIT = 7;
    localparam int PRESCALE_BIT = 10;
    // Counter and timing
    localparam int CNT_W = 21;
    localparam logic [7:0] PRESCALE_LAST = 8'hFF;
    localparam logic [10:0] RESET_DELAY = 11'h400;
    localparam logic [20:0] TIMEOUT_SEL0 = 21'h004000;
    localparam logic [20:0] TIMEOUT_SEL1 = 21'h010000;
    localparam logic [20:0] TIMEOUT_SEL2 = 21'h040000;
    localparam logic [20:0] TIMEOUT_SEL3 = 21'h100000;
endpackage

// File: wdt_timeout_flags.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Interrupt enable bit 6 gates the interrupt request; zero suppresses it.
// - Reset timeout is interrupt timeout plus fixed delay, taken as 1024 watchdog clock ticks.
// - Expiry with interrupt enabled sets interrupt flag bit 3.
// - Flag also set when disabled; read only, cleared by writing one.
// - Watchdog-initiated reset sets reset flag bit 2.
// - Reset flag survives watchdog reset until software writes one to clear it.
// - With reset enable zero, no reset and reset flag untouched.
// - Timer enable runs counter; clearing it stops and zeroes the count.
// - Writing one to kick restarts the count; kick self-clears.
// - Reset enable bit 1 allows the reset after timeout.
// - Prescale bit selects undivided crystal or crystal divided by 256.
module wdt_timeout_flags
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // System side
    output logic WDT_IRQ,
    output logic WDT_RESET_REQ
);
    logic run_en_reg, irq_en_reg, rst_en_reg, prescale_reg;
    logic [1:0] sel_reg;
    logic irq_flag_reg, rst_flag_reg;
    logic [7:0] div_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [10:0] dly_reg;
    logic expired_reg, rst_pulse_reg;
    logic [31:0] prdata_reg;
    logic wr_ctrl, rd_ctrl, hit, tick, kick, timeout;
    logic [CNT_W-1:0] limit;

    assign hit = (PADDR == WDT_CTRL_ADDR);
    assign wr_ctrl = PSEL && PENABLE && PWRITE && hit;
    assign rd_ctrl = PSEL && !PENABLE && !PWRITE;
    assign kick = wr_ctrl && PWDATA[KICK_BIT];
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign PRDATA = prdata_reg;

    // Control fields
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            run_en_reg <= WDT_CTRL_RESET[RUN_EN_BIT];
            irq_en_reg <= WDT_CTRL_RESET[IRQ_EN_BIT];
            rst_en_reg <= WDT_CTRL_RESET[RST_EN_BIT];
            prescale_reg <= WDT_CTRL_RESET[PRESCALE_BIT];
            sel_reg <= WDT_CTRL_RESET[SEL_LO_BIT +: 2];
        end else if (wr_ctrl) begin
            run_en_reg <= PWDATA[RUN_EN_BIT];
            irq_en_reg <= PWDATA[IRQ_EN_BIT];
            rst_en_reg <= PWDATA[RST_EN_BIT];
            prescale_reg <= PWDATA[PRESCALE_BIT];
            sel_reg <= PWDATA[SEL_LO_BIT +: 2];
        end
    end

    // Read data registered in the setup cycle; kick always reads zero
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_ctrl) begin
            prdata_reg <= 32'h0000_0000;
            if (hit) begin
                prdata_reg[RUN_EN_BIT] <= run_en_reg;
                prdata_reg[IRQ_EN_BIT] <= irq_en_reg;
                prdata_reg[SEL_LO_BIT +: 2] <= sel_reg;
                prdata_reg[IRQ_FLAG_BIT] <= irq_flag_reg;
                prdata_reg[RST_FLAG_BIT] <= rst_flag_reg;
                prdata_reg[RST_EN_BIT] <= rst_en_reg;
                prdata_reg[PRESCALE_BIT] <= prescale_reg;
            end
        end
    end

    // Prescaler gives a one-cycle tick per watchdog clock
    always_ff @(posedge CLK) begin
        if (!RESETN || !run_en_reg || kick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign tick = run_en_reg && (!prescale_reg || div_reg == PRESCALE_LAST);

    always_comb begin
        case (sel_reg)
            2'b00: limit = TIMEOUT_SEL0;
            2'b01: limit = TIMEOUT_SEL1;
            2'b10: limit = TIMEOUT_SEL2;
            2'b11: limit = TIMEOUT_SEL3;
            default: limit = TIMEOUT_SEL0;
        endcase
    end
    assign timeout = tick && !expired_reg && (cnt_reg == limit - 21'h000001);

    // Interrupt count phase
    always_ff @(posedge CLK) begin
        if (!RESETN || !run_en_reg || kick) begin
            cnt_reg <= '0;
            expired_reg <= 1'b0;
        end else if (timeout) begin
            expired_reg <= 1'b1;
        end else if (tick && !expired_reg) begin
            cnt_reg <= cnt_reg + 21'h000001;
        end
    end

    // Reset delay phase after the interrupt timeout
    always_ff @(posedge CLK) begin
        if (!RESETN || !run_en_reg || kick) begin
            dly_reg <= '0;
            rst_pulse_reg <= 1'b0;
        end else begin
            rst_pulse_reg <= 1'b0;
            if (expired_reg && tick && dly_reg != RESET_DELAY) begin
                dly_reg <= dly_reg + 11'h001;
                if (dly_reg == RESET_DELAY - 11'h001 && rst_en_reg) begin
                    rst_pulse_reg <= 1'b1;
                end
            end
        end
    end
    assign WDT_RESET_REQ = rst_pulse_reg;

    // Interrupt flag: set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            irq_flag_reg <= 1'b0;
        end else if (timeout) begin
            irq_flag_reg <= 1'b1;
        end else if (wr_ctrl && PWDATA[IRQ_FLAG_BIT]) begin
            irq_flag_reg <= 1'b0;
        end
    end

    // Reset flag is not cleared by RESETN so it survives the reset it causes;
    // system reset must not be wired to RESETN of this block alone if power-on
    // clearing is wanted, hence the flag starts from zero only by software.
    always_ff @(posedge CLK) begin
        if (rst_pulse_reg) begin
            rst_flag_reg <= 1'b1;
        end else if (wr_ctrl && PWDATA[RST_FLAG_BIT]) begin
            rst_flag_reg <= 1'b0;
        end
    end

    assign WDT_IRQ = irq_flag_reg && irq_en_reg;

    count_bound_a: assert property (@(posedge CLK) disable iff (!RESETN)
        run_en_reg |-> cnt_reg <= limit) else $error("count beyond limit");
    irq_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !irq_en_reg |-> !WDT_IRQ) else $error("irq not gated");
    irq_flag_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
        timeout |=> irq_flag_reg) else $error("irq flag not set");
    irq_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl && PWDATA[IRQ_FLAG_BIT] && !timeout |=> !irq_flag_reg)
        else $error("irq flag not cleared");
    rst_flag_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
        rst_pulse_reg |=> rst_flag_reg) else $error("reset flag not set");
    no_reset_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !$past(rst_en_reg) |-> !WDT_RESET_REQ) else $error("reset while disabled");
    stop_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !run_en_reg |=> cnt_reg == '0) else $error("count not cleared");
    kick_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
        kick |=> cnt_reg == '0 && !expired_reg) else $error("kick ignored");
    irq_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
        WDT_IRQ && !wr_ctrl |=> WDT_IRQ) else $error("irq dropped");

    // Bus side: zero wait states, so every access phase must see ready
    ready_now_a: assert property (@(posedge CLK) disable iff (!RESETN)
        PSEL && PENABLE |-> PREADY) else $error("ready not high");

    slave_error_a: assert property (@(posedge CLK) disable iff (!RESETN)
        PSEL && PENABLE |-> PSLVERR == !hit) else $error("error response wrong");

    // Unmapped reads return zero and unmapped writes leave every field alone
    unmapped_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_ctrl && !hit |=> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    unmapped_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        PSEL && PENABLE && PWRITE && !hit |=> $stable(sel_reg) && $stable(run_en_reg)
        && $stable(irq_en_reg) && $stable(rst_en_reg) && $stable(prescale_reg))
        else $error("unmapped write took effect");

    // Read data stands between setup reads
    read_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !rd_ctrl |=> $stable(PRDATA)) else $error("read data moved");

    kick_reads_a: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_ctrl |=> !PRDATA[KICK_BIT]) else $error("kick read back");

    reserved_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_ctrl |=> PRDATA[31:11] == 21'h000000) else $error("reserved bits set");

    flag_readback_a: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_ctrl && hit |=> PRDATA[IRQ_FLAG_BIT] == $past(irq_flag_reg))
        else $error("irq flag read wrong");

    // A full-word write rewrites every control field
    run_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl |=> run_en_reg == $past(PWDATA[RUN_EN_BIT]))
        else $error("run enable not written");

    ien_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl |=> irq_en_reg == $past(PWDATA[IRQ_EN_BIT]))
        else $error("irq enable not written");

    ren_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl |=> rst_en_reg == $past(PWDATA[RST_EN_BIT]))
        else $error("reset enable not written");

    sel_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl |=> sel_reg == $past(PWDATA[SEL_LO_BIT +: 2]))
        else $error("interval not written");

    pre_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl |=> prescale_reg == $past(PWDATA[PRESCALE_BIT]))
        else $error("prescale not written");

    // Watchdog clock: none while stopped, one per CLK or one per 256 CLK
    tick_stop_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !run_en_reg |-> !tick) else $error("tick while stopped");

    tick_div_a: assert property (@(posedge CLK) disable iff (!RESETN)
        prescale_reg && tick |-> div_reg == PRESCALE_LAST)
        else $error("divided tick early");

    tick_full_a: assert property (@(posedge CLK) disable iff (!RESETN)
        run_en_reg && !prescale_reg |-> tick) else $error("undivided tick missing");

    // Kick is a multi-step restart: the write, then a fully cleared counter
    sequence kick_write_s;
        wr_ctrl && PWDATA[KICK_BIT];
    endsequence

    sequence counter_clear_s;
        cnt_reg == '0 && dly_reg == '0 && !expired_reg && !WDT_RESET_REQ;
    endsequence

    sequence counting_s;
        run_en_reg && !kick && tick && !expired_reg && !timeout;
    endsequence

    kick_restart_a: assert property (@(posedge CLK) disable iff (!RESETN)
        kick_write_s |=> counter_clear_s) else $error("kick did not restart");

    count_step_a: assert property (@(posedge CLK) disable iff (!RESETN)
        counting_s |=> cnt_reg == $past(cnt_reg) + 21'h000001)
        else $error("count did not step");

    expired_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
        expired_reg && run_en_reg && !kick |=> expired_reg)
        else $error("expiry lost");

    flag_source_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !irq_flag_reg && !timeout |=> !irq_flag_reg)
        else $error("irq flag set without timeout");

    // Reset delay phase only after expiry, pulse exactly at its end
    delay_after_a: assert property (@(posedge CLK) disable iff (!RESETN)
        dly_reg != '0 |-> expired_reg) else $error("delay before expiry");

    delay_bound_a: assert property (@(posedge CLK) disable iff (!RESETN)
        dly_reg <= RESET_DELAY) else $error("delay overran");

    pulse_end_a: assert property (@(posedge CLK) disable iff (!RESETN)
        WDT_RESET_REQ |-> dly_reg == RESET_DELAY)
        else $error("reset pulse off delay end");

    pulse_single_a: assert property (@(posedge CLK) disable iff (!RESETN)
        WDT_RESET_REQ |=> !WDT_RESET_REQ) else $error("reset pulse too long");

    // The reset flag must outlive RESETN, so no disable here
    rst_flag_hold_a: assert property (@(posedge CLK)
        rst_flag_reg && !(wr_ctrl && PWDATA[RST_FLAG_BIT]) |=> rst_flag_reg)
        else $error("reset flag lost");

    rst_flag_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl && PWDATA[RST_FLAG_BIT] && !rst_pulse_reg |=> !rst_flag_reg)
        else $error("reset flag not cleared");
endmodule

// File: watchdog_timeout_flags_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module watchdog_timeout_flags_tb;
    import wdt_pkg::*;
    logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, WDT_IRQ, WDT_RESET_REQ;
    logic [32:0] exp_q[$];
    int err_total = 0, n_compared = 0, cnt = 0, pulses = 0, seed = 32'hBBA0;
    wdt_timeout_flags wdt_timeout_flags_inst (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .WDT_IRQ(WDT_IRQ), .WDT_RESET_REQ(WDT_RESET_REQ));
    initial forever #20 CLK = ~CLK;
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reads note {PSLVERR, PRDATA}; the monitor below compares at the access edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        if (!wr) exp_q.push_back(e);
        PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic wait_for(input int which, input int lim);
        cnt = 0;
        do begin @(posedge CLK); cnt++; end
        while (((which == 1) ? WDT_RESET_REQ : WDT_IRQ) !== 1'b1 && cnt < lim);
        if (cnt >= lim) begin err_total++; $display("wait limit reached"); end
    endtask
    always @(posedge CLK) begin
        if (WDT_RESET_REQ === 1'b1) pulses++;
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
            if (exp_q.size() == 0) begin err_total++; $display("unexpected read"); end
            else `CHK({PSLVERR, PRDATA}, exp_q.pop_front())
        end
    end
    initial begin
        #(40 * 90000);
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        // Reset flag powers up undefined, so clear it before the first full read
        apb(1, WDT_CTRL_ADDR, 32'h0000_0404, 0);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, WDT_CTRL_RESET});
        apb(1, 12'h020, $random(seed), 0);
        apb(0, 12'h020, 0, 33'h1_0000_0000);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, WDT_CTRL_RESET});
        $display("test registers done");
        apb(1, WDT_CTRL_ADDR, 32'h0000_0080, 0);
        repeat (10000) @(posedge CLK);
        apb(1, WDT_CTRL_ADDR, 32'h0000_0081, 0);
        repeat (10000) @(posedge CLK);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, 32'h0000_0080});
        repeat (7000) @(posedge CLK);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, 32'h0000_0088});
        `CHK(WDT_IRQ, 1'b0)
        repeat (1000) @(posedge CLK);
        `CHK(pulses, 0)
        apb(1, WDT_CTRL_ADDR, 32'h0000_0008, 0);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, 32'h0000_0000});
        $display("test kick and disabled interrupt done");
        apb(1, WDT_CTRL_ADDR, 32'h0000_0480, 0);
        repeat (17000) @(posedge CLK);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, 32'h0000_0480});
        apb(1, WDT_CTRL_ADDR, 32'h0000_00C3, 0);
        wait_for(0, 20000);
        `CHK(cnt >= 16380 && cnt <= 16390, 1'b1)
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, 32'h0000_00CA});
        wait_for(1, 2000);
        `CHK(cnt >= 1014 && cnt <= 1028, 1'b1)
        @(posedge CLK);
        `CHK(WDT_RESET_REQ, 1'b0)
        // The system answers the request with a reset; the flag must outlive it
        RESETN <= 1'b0;
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, WDT_CTRL_RESET | 32'h0000_0004});
        `CHK(WDT_IRQ, 1'b0)
        apb(1, WDT_CTRL_ADDR, 32'h0000_0404, 0);
        apb(0, WDT_CTRL_ADDR, 0, {1'b0, WDT_CTRL_RESET});
        $display("test timeout and reset done");
        end_of_test;
    end
endmodule
